/* File: verilog/pc_pointer_and_stack_unit.v */
// Program counter, pointer registers, addressing modes and return stack
`timescale 1ns/1ps
`include "pc_stack_regs.vh"
// Overview of operation
// RULE1 - Low byte add carry bumps high byte
// RULE2 - Low byte borrow leaves high byte alone
// RULE3 - Move to low byte jumps within page
// RULE4 - Pointer one: high is bank, low location
// RULE5 - Pointer two: high is bank, low location
// RULE6 - Pointer two addresses ROM for lookups
// RULE7 - Lookup: high to result, low to accumulator
// RULE8 - Immediate to RAM only 0x80 to 0x87
// RULE9 - Direct mode; bank-0 move forces bank 0
// RULE10 - Eight entries, push on call and interrupt
// RULE11 - Push decrements, pop increments index
// RULE12 - Entry: upper nibble high, low byte
// RULE13 - Index bit 7 is interrupt enable, resets 0
// RULE14 - Software initialises index to 111
// RULE15 - 12-bit counter; jump loads all bits
// RULE16 - Returns pop newest entry into counter
// RULE17 - Pointer registers plain readable writable memory
module pc_pointer_and_stack_unit #(
	parameter PC_BITS = 12,
	parameter DEPTH_BITS = 3
) (
	input wire sys_clk,
	input wire rst_b,
	input wire op_valid,
	input wire [3:0] op_code,
	input wire [PC_BITS-1:0] op_target,
	input wire [7:0] op_literal,
	input wire [7:0] op_ram_addr,
	input wire op_bank0,
	input wire op_use_pointer_two,
	input wire op_indirect_write,
	input wire [7:0] ram_bank_sel,
	input wire [7:0] ram_rdata,
	input wire [15:0] rom_rdata,
	input wire reg_write,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	output wire [PC_BITS-1:0] program_counter,
	output wire [PC_BITS-1:0] rom_addr,
	output reg [7:0] ram_bank,
	output reg [7:0] ram_addr,
	output reg ram_we,
	output reg [7:0] ram_wdata,
	output reg imm_refused,
	output wire [7:0] accumulator,
	output wire [DEPTH_BITS-1:0] return_index_bits,
	output wire global_irq_enable
);
	reg [PC_BITS-1:0] pc_q;
	reg [7:0] accumulator_q;
	reg [7:0] pointer_one_low_q;
	reg [7:0] pointer_one_high_q;
	reg [7:0] lookup_result_high_q;
	reg [7:0] pointer_two_low_q;
	reg [7:0] pointer_two_high_q;
	reg global_irq_enable_q;
	reg [PC_BITS-1:0] pc_d;
	reg [PC_BITS-1:0] pc_next_seq;
	wire [8:0] low_sum;
	wire [PC_BITS-1:0] stack_top;
	wire [PC_BITS-1:0] stack_sel;
	wire [DEPTH_BITS-1:0] stack_index;
	wire do_push;
	wire do_pop;
	wire index_write;
	wire entry_upper_write;
	wire entry_lower_write;
	wire [DEPTH_BITS-1:0] entry_sel;
	wire imm_ok;
	wire [7:0] counter_low_byte;
	wire [PC_BITS-9:0] counter_high_byte;
	wire lookup_go;
	wire imm_acc_go;
	wire direct_read_go;
	wire indirect_go;
	wire call_go;
	wire irq_entry_go;
	wire ret_go;
	wire irq_ret_go;
	wire wr_pointer_one_low;
	wire wr_pointer_one_high;
	wire wr_lookup_result_high;
	wire wr_pointer_two_low;
	wire wr_pointer_two_high;
	wire [PC_BITS-1:0] pc_skip;
	wire [PC_BITS-1:0] pc_add_carry;
	wire [PC_BITS-1:0] pc_sub_page;
	wire [PC_BITS-1:0] pc_move_page;
	wire [7:0] index_readback;
	wire [7:0] entry_upper_readback;
	wire [7:0] entry_lower_readback;

	// True when an address hits the 16-byte stack entry window
	function is_entry;
		input [7:0] a;
		begin
			is_entry = (a[7:4] == `OFS_RETURN_ENTRY_BASE >> 4);
		end
	endfunction

	// Entry window interleaves: even offsets upper, odd lower
	function [DEPTH_BITS-1:0] entry_of;
		input [7:0] a;
		begin
			entry_of = a[DEPTH_BITS:1];
		end
	endfunction

	// Software write strobe decode, shared by the pointer, lookup-result and index registers
	function reg_hit;
		input wr;
		input [7:0] a;
		input [7:0] ofs;
		begin
			reg_hit = wr && a == ofs;
		end
	endfunction

	// Instruction decode, qualified by the valid strobe
	function op_hit;
		input valid;
		input [3:0] code;
		input [3:0] want;
		begin
			op_hit = valid && code == want;
		end
	endfunction

	assign counter_low_byte = pc_q[7:0];
	assign counter_high_byte = pc_q[PC_BITS-1:8];
	assign program_counter = pc_q;
	assign accumulator = accumulator_q;
	assign return_index_bits = stack_index;
	assign global_irq_enable = global_irq_enable_q;
	assign rom_addr = {pointer_two_high_q[PC_BITS-9:0], pointer_two_low_q}; // RULE6
	assign low_sum = {1'b0, counter_low_byte} + {1'b0, accumulator_q};
	assign imm_ok = op_ram_addr >= `IMM_RAM_LOW && op_ram_addr <= `IMM_RAM_HIGH; // RULE8
	// Instruction strobes
	assign lookup_go = op_hit(op_valid, op_code, `OP_TABLE_LOOKUP);
	assign imm_acc_go = op_hit(op_valid, op_code, `OP_IMM_TO_ACC);
	assign direct_read_go = op_hit(op_valid, op_code, `OP_DIRECT_READ);
	assign indirect_go = op_hit(op_valid, op_code, `OP_INDIRECT);
	assign call_go = op_hit(op_valid, op_code, `OP_CALL);
	assign irq_entry_go = op_hit(op_valid, op_code, `OP_IRQ_ENTRY);
	assign ret_go = op_hit(op_valid, op_code, `OP_RETURN);
	assign irq_ret_go = op_hit(op_valid, op_code, `OP_IRQ_RETURN);
	// One op per cycle, so a push and a pop never meet
	assign do_push = call_go || irq_entry_go; // RULE10
	assign do_pop = ret_go || irq_ret_go; // RULE16

	// Software write strobes
	assign index_write = reg_hit(reg_write, reg_addr, `OFS_RETURN_STACK_INDEX);
	assign wr_pointer_one_low = reg_hit(reg_write, reg_addr, `OFS_POINTER_ONE_LOW);
	assign wr_pointer_one_high = reg_hit(reg_write, reg_addr, `OFS_POINTER_ONE_HIGH);
	assign wr_lookup_result_high = reg_hit(reg_write, reg_addr, `OFS_LOOKUP_RESULT_HIGH);
	assign wr_pointer_two_low = reg_hit(reg_write, reg_addr, `OFS_POINTER_TWO_LOW);
	assign wr_pointer_two_high = reg_hit(reg_write, reg_addr, `OFS_POINTER_TWO_HIGH);
	assign entry_upper_write = reg_write && is_entry(reg_addr) && !reg_addr[0];
	assign entry_lower_write = reg_write && is_entry(reg_addr) && reg_addr[0];
	assign entry_sel = entry_of(reg_addr);

	// Candidate next counter values
	assign pc_skip = pc_q + {{(PC_BITS-2){1'b0}}, 2'b10};
	// Carry out of the low byte rides into the high byte
	assign pc_add_carry = {counter_high_byte + {{(PC_BITS-9){1'b0}}, low_sum[8]}, low_sum[7:0]}; // RULE1
	// Borrow is dropped: high byte never counts down
	assign pc_sub_page = {counter_high_byte, counter_low_byte - accumulator_q}; // RULE2
	assign pc_move_page = {counter_high_byte, accumulator_q}; // RULE3

	// Read-back words; unused entry bits read as zero
	assign index_readback = {global_irq_enable_q, {(7-DEPTH_BITS){1'b0}}, stack_index}; // RULE13
	assign entry_upper_readback = {{(16-PC_BITS){1'b0}}, stack_sel[PC_BITS-1:8]}; // RULE12
	assign entry_lower_readback = stack_sel[7:0];

	return_stack #(
		.DEPTH_BITS(DEPTH_BITS),
		.PC_BITS(PC_BITS)
	) u_stack (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.push(do_push),
		.pop(do_pop),
		.push_value(pc_next_seq),
		.index_write(index_write),
		.index_wdata(reg_wdata[DEPTH_BITS-1:0]),
		.entry_write_upper(entry_upper_write),
		.entry_write_lower(entry_lower_write),
		.entry_sel(entry_sel),
		.entry_wdata(reg_wdata),
		.index(stack_index),
		.top_value(stack_top),
		.sel_value(stack_sel)
	);

	// Next program counter
	always @* begin
		pc_next_seq = pc_q + {{(PC_BITS-1){1'b0}}, 1'b1}; // RULE15
		pc_d = pc_next_seq;
		if (op_valid) begin
			case (op_code)
				`OP_JUMP, `OP_CALL: pc_d = op_target; // RULE15
				`OP_IRQ_ENTRY: pc_d = op_target;
				`OP_RETURN, `OP_IRQ_RETURN: pc_d = stack_top; // RULE16
				`OP_SKIP: pc_d = pc_skip;
				`OP_PCL_ADD: pc_d = pc_add_carry; // RULE1
				`OP_PCL_SUB: pc_d = pc_sub_page; // RULE2
				`OP_PCL_MOVE: pc_d = pc_move_page; // RULE3
				`OP_NOP, `OP_TABLE_LOOKUP, `OP_IMM_TO_ACC, `OP_IMM_TO_RAM: pc_d = pc_next_seq;
				`OP_DIRECT_READ, `OP_DIRECT_WRITE, `OP_INDIRECT: pc_d = pc_next_seq;
				default: pc_d = pc_next_seq;
			endcase
		end else begin
			pc_d = pc_q;
		end
	end

	// Data memory port for immediate, direct and indirect modes
	always @* begin
		ram_bank = ram_bank_sel;
		ram_addr = op_ram_addr;
		ram_we = 1'b0;
		ram_wdata = accumulator_q;
		imm_refused = 1'b0;
		if (op_valid) begin
			case (op_code)
				`OP_IMM_TO_RAM: begin
					ram_bank = 8'h00;
					ram_we = imm_ok; // RULE8
					ram_wdata = op_literal;
					imm_refused = !imm_ok;
				end
				`OP_DIRECT_READ, `OP_DIRECT_WRITE: begin
					if (op_bank0) begin
						ram_bank = 8'h00; // RULE9
					end
					ram_we = op_code == `OP_DIRECT_WRITE; // RULE9
				end
				`OP_INDIRECT: begin
					if (op_use_pointer_two) begin
						ram_bank = pointer_two_high_q; // RULE5
						ram_addr = pointer_two_low_q; // RULE5
					end else begin
						ram_bank = pointer_one_high_q; // RULE4
						ram_addr = pointer_one_low_q; // RULE4
					end
					ram_we = op_indirect_write;
				end
				default: ram_we = 1'b0;
			endcase
		end
	end

	// Register read-back
	always @* begin
		reg_rdata = 8'h00;
		if (is_entry(reg_addr)) begin
			if (reg_addr[0]) begin
				reg_rdata = entry_lower_readback;
			end else begin
				reg_rdata = entry_upper_readback; // RULE12
			end
		end else begin
			case (reg_addr)
				`OFS_POINTER_ONE_LOW: reg_rdata = pointer_one_low_q; // RULE17
				`OFS_POINTER_ONE_HIGH: reg_rdata = pointer_one_high_q;
				`OFS_LOOKUP_RESULT_HIGH: reg_rdata = lookup_result_high_q;
				`OFS_POINTER_TWO_LOW: reg_rdata = pointer_two_low_q;
				`OFS_POINTER_TWO_HIGH: reg_rdata = pointer_two_high_q;
				`OFS_RETURN_STACK_INDEX: reg_rdata = index_readback; // RULE13
				default: reg_rdata = 8'h00;
			endcase
		end
	end

	// Counter holds whenever no instruction is in flight
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			pc_q <= `PC_RESET;
		end else begin
			pc_q <= pc_d;
		end
	end

	// One op per cycle, so at most one of these loads applies
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			accumulator_q <= 8'h00;
		end else if (lookup_go) begin
			accumulator_q <= rom_rdata[7:0]; // RULE7
		end else if (imm_acc_go) begin
			accumulator_q <= op_literal; // RULE8
		end else if (direct_read_go) begin
			accumulator_q <= ram_rdata; // RULE9
		end else if (indirect_go && !op_indirect_write) begin
			accumulator_q <= ram_rdata;
		end
	end

	// Pointer contents are undefined at power-up; cleared here for determinism
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			pointer_one_low_q <= 8'h00;
			pointer_one_high_q <= 8'h00;
			pointer_two_low_q <= 8'h00;
			pointer_two_high_q <= 8'h00;
		end else begin
			if (wr_pointer_one_low) begin
				pointer_one_low_q <= reg_wdata; // RULE17
			end
			if (wr_pointer_one_high) begin
				pointer_one_high_q <= reg_wdata;
			end
			if (wr_pointer_two_low) begin
				pointer_two_low_q <= reg_wdata; // RULE6
			end
			if (wr_pointer_two_high) begin
				pointer_two_high_q <= reg_wdata;
			end
		end
	end

	// Lookup wins over a same-cycle software write
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			lookup_result_high_q <= 8'h00;
		end else if (lookup_go) begin
			lookup_result_high_q <= rom_rdata[15:8]; // RULE7
		end else if (wr_lookup_result_high) begin
			lookup_result_high_q <= reg_wdata;
		end
	end

	// Enable bit shares the index address but lives outside the stack
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			global_irq_enable_q <= 1'b0; // RULE13
		end else if (index_write) begin
			global_irq_enable_q <= reg_wdata[`IRQ_ENABLE_BIT]; // RULE13
		end
	end
endmodule // pc_pointer_and_stack_unit

/* File: verilog/pc_stack_regs.vh */
// Register offsets, reset values and opcode encodings for the pointer and stack unit
`ifndef PC_STACK_REGS_VH
`define PC_STACK_REGS_VH
`define OFS_POINTER_ONE_LOW 8'h80
`define OFS_POINTER_ONE_HIGH 8'h81
`define OFS_LOOKUP_RESULT_HIGH 8'h82
`define OFS_POINTER_TWO_LOW 8'h83
`define OFS_POINTER_TWO_HIGH 8'h84
`define OFS_RETURN_STACK_INDEX 8'hDF
`define OFS_RETURN_ENTRY_BASE 8'hF0
`define IMM_RAM_LOW 8'h80
`define IMM_RAM_HIGH 8'h87
`define STACK_INDEX_RESET 3'h7
`define IRQ_ENABLE_BIT 7
`define PC_RESET 12'h000
`define OP_NOP 4'h0
`define OP_JUMP 4'h1
`define OP_CALL 4'h2
`define OP_RETURN 4'h3
`define OP_IRQ_RETURN 4'h4
`define OP_IRQ_ENTRY 4'h5
`define OP_SKIP 4'h6
`define OP_PCL_ADD 4'h7
`define OP_PCL_SUB 4'h8
`define OP_PCL_MOVE 4'h9
`define OP_TABLE_LOOKUP 4'hA
`define OP_IMM_TO_ACC 4'hB
`define OP_IMM_TO_RAM 4'hC
`define OP_DIRECT_READ 4'hD
`define OP_DIRECT_WRITE 4'hE
`define OP_INDIRECT 4'hF
`endif

/* File: verilog/return_stack.v */
// Eight-level return-address stack with its 3-bit index
`timescale 1ns/1ps
`include "pc_stack_regs.vh"
module return_stack #(
	parameter DEPTH_BITS = 3,
	parameter PC_BITS = 12
) (
	input wire sys_clk,
	input wire rst_b,
	input wire push,
	input wire pop,
	input wire [PC_BITS-1:0] push_value,
	input wire index_write,
	input wire [DEPTH_BITS-1:0] index_wdata,
	input wire entry_write_upper,
	input wire entry_write_lower,
	input wire [DEPTH_BITS-1:0] entry_sel,
	input wire [7:0] entry_wdata,
	output wire [DEPTH_BITS-1:0] index,
	output wire [PC_BITS-1:0] top_value,
	output wire [PC_BITS-1:0] sel_value
);
	localparam DEPTH = 1 << DEPTH_BITS;
	reg [DEPTH_BITS-1:0] index_q;
	reg [PC_BITS-1:0] entry_q [0:DEPTH-1];
	wire [DEPTH_BITS-1:0] pop_slot;
	assign pop_slot = index_q + {{(DEPTH_BITS-1){1'b0}}, 1'b1};
	assign index = index_q;
	assign top_value = entry_q[pop_slot];
	assign sel_value = entry_q[entry_sel];
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			index_q <= `STACK_INDEX_RESET; // RULE13
		end else if (push) begin
			index_q <= index_q - {{(DEPTH_BITS-1){1'b0}}, 1'b1}; // RULE11
		end else if (pop) begin
			index_q <= pop_slot; // RULE11
		end else if (index_write) begin
			index_q <= index_wdata;
		end
	end
	genvar g;
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : slot
			always @(posedge sys_clk) begin
				if (!rst_b) begin
					entry_q[g] <= {PC_BITS{1'b0}};
				end else if (push && index_q == g) begin
					entry_q[g] <= push_value; // RULE10
				end else if (entry_write_upper && entry_sel == g) begin
					entry_q[g][PC_BITS-1:8] <= entry_wdata[PC_BITS-9:0]; // RULE12
				end else if (entry_write_lower && entry_sel == g) begin
					entry_q[g][7:0] <= entry_wdata; // RULE12
				end
			end
		end
	endgenerate
endmodule // return_stack

/* File: sim/pc_stack_monitor.sv */
// Port checker for the pointer and stack unit
`timescale 1ns/1ps
`include "pc_stack_regs.vh"
module pc_stack_monitor #(
	parameter PC_BITS = 12,
	parameter DEPTH_BITS = 3
) (
	input logic sys_clk,
	input logic rst_b,
	input logic op_valid,
	input logic [3:0] op_code,
	input logic [PC_BITS-1:0] op_target,
	input logic [7:0] op_ram_addr,
	input logic op_bank0,
	input logic [15:0] rom_rdata,
	input logic [PC_BITS-1:0] program_counter,
	input logic [7:0] ram_bank,
	input logic ram_we,
	input logic [7:0] ram_wdata,
	input logic imm_refused,
	input logic [7:0] accumulator,
	input logic [DEPTH_BITS-1:0] return_index_bits,
	input logic global_irq_enable
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_jump;
		op_valid && op_code == `OP_JUMP |=> program_counter == $past(op_target);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target not loaded");
	property p_push;
		op_valid && (op_code == `OP_CALL || op_code == `OP_IRQ_ENTRY) |=>
			program_counter == $past(op_target) && return_index_bits + 3'h1 == $past(return_index_bits);
	endproperty
	a_push: assert property (p_push) else $error("push wrong");
	property p_pop;
		op_valid && (op_code == `OP_RETURN || op_code == `OP_IRQ_RETURN) |=>
			return_index_bits == $past(return_index_bits) + 3'h1;
	endproperty
	a_pop: assert property (p_pop) else $error("pop index wrong");
	property p_carry;
		op_valid && op_code == `OP_PCL_ADD && ({1'b0, program_counter[7:0]} + accumulator > 9'h0FF) |=>
			program_counter[11:8] == $past(program_counter[11:8]) + 4'h1;
	endproperty
	a_carry: assert property (p_carry) else $error("carry not taken");
	property p_borrow;
		op_valid && op_code == `OP_PCL_SUB |=> $stable(program_counter[11:8]);
	endproperty
	a_borrow: assert property (p_borrow) else $error("high byte moved");
	property p_move;
		op_valid && op_code == `OP_PCL_MOVE |=>
			program_counter == {$past(program_counter[11:8]), $past(accumulator)};
	endproperty
	a_move: assert property (p_move) else $error("page jump wrong");
	property p_lookup;
		op_valid && op_code == `OP_TABLE_LOOKUP |=> accumulator == $past(rom_rdata[7:0]);
	endproperty
	a_lookup: assert property (p_lookup) else $error("lookup low byte");
	property p_refuse;
		op_valid && op_code == `OP_IMM_TO_RAM && (op_ram_addr < `IMM_RAM_LOW || op_ram_addr > `IMM_RAM_HIGH)
			|-> imm_refused && !ram_we;
	endproperty
	a_refuse: assert property (p_refuse) else $error("immediate not refused");
	property p_bank0;
		op_valid && op_code == `OP_DIRECT_WRITE && op_bank0 |-> ram_we && ram_bank == 8'h00 && ram_wdata == accumulator;
	endproperty
	a_bank0: assert property (p_bank0) else $error("bank0 write wrong");
	property p_reset;
		$rose(rst_b) |-> !global_irq_enable && return_index_bits == `STACK_INDEX_RESET;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule // pc_stack_monitor
bind pc_pointer_and_stack_unit pc_stack_monitor #(.PC_BITS(PC_BITS), .DEPTH_BITS(DEPTH_BITS)) i_mon (.*);

/* File: sim/test_pc_pointer_and_stack_unit.sv */
// Directed testbench for the pointer and stack unit
`timescale 1ns/1ps
`include "pc_stack_regs.vh"
module test_pc_pointer_and_stack_unit;
	logic sys_clk = 0, rst_b = 0, op_valid = 0, op_bank0 = 0, op_use_pointer_two = 0, op_indirect_write = 0;
	logic reg_write = 0, ram_we, imm_refused, global_irq_enable;
	logic [3:0] op_code = 0;
	logic [11:0] op_target = 0, program_counter, rom_addr;
	logic [7:0] op_literal = 0, op_ram_addr = 0, ram_bank_sel = 8'h05, ram_rdata = 0, reg_addr = 0, reg_wdata = 0;
	logic [7:0] reg_rdata, ram_bank, ram_addr, ram_wdata, accumulator, i;
	logic [15:0] rom_rdata = 0;
	logic [2:0] return_index_bits;
	logic [17:0] seen;
	logic [7:0] sw;
	logic [7:0] ia [4] = '{8'h7F, 8'h80, 8'h87, 8'h88};
	logic ok;
	int err_total = 0, check_count = 0, cyc = 0;
	pc_pointer_and_stack_unit i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
		.op_target(op_target), .op_literal(op_literal), .op_ram_addr(op_ram_addr), .op_bank0(op_bank0),
		.op_use_pointer_two(op_use_pointer_two), .op_indirect_write(op_indirect_write), .ram_bank_sel(ram_bank_sel),
		.ram_rdata(ram_rdata), .rom_rdata(rom_rdata), .reg_write(reg_write), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .program_counter(program_counter), .rom_addr(rom_addr),
		.ram_bank(ram_bank), .ram_addr(ram_addr), .ram_we(ram_we), .ram_wdata(ram_wdata),
		.imm_refused(imm_refused), .accumulator(accumulator), .return_index_bits(return_index_bits),
		.global_irq_enable(global_irq_enable));
	initial forever #10 sys_clk = ~sys_clk;
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_write <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input string n);
		@(posedge sys_clk);
		reg_addr <= a;
		#1;
		chk(n, e, reg_rdata);
	endtask
	// RAM port is combinational, so it is sampled while the op is still held
	task op(input logic [3:0] c, input logic [11:0] t, input logic [7:0] l, a, input logic [2:0] f,
		input logic [15:0] d);
		@(posedge sys_clk);
		op_valid <= 1'b1;
		op_code <= c;
		op_target <= t;
		op_literal <= l;
		op_ram_addr <= a;
		{op_bank0, op_use_pointer_two, op_indirect_write} <= f;
		rom_rdata <= d;
		ram_rdata <= d[7:0];
		#5;
		seen = {ram_we, imm_refused, ram_bank, ram_addr};
		sw = ram_wdata;
		@(posedge sys_clk);
		op_valid <= 1'b0;
		#1;
	endtask
	task close_out;
		$display("Comparisons %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Generous ceiling; the directed run needs about a hundred cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			close_out;
		end
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(`OFS_RETURN_STACK_INDEX, 8'h07, "index reset");
		wr(`OFS_RETURN_STACK_INDEX, 8'h87);
		chk("irq on", 1, global_irq_enable);
		wr(`OFS_RETURN_STACK_INDEX, 8'h07);
		chk("irq off", 0, global_irq_enable);
		for (i = 8'h00; i < 8'h05; i++)
			wr(8'h80 + i, 8'hA0 + i);
		for (i = 8'h00; i < 8'h05; i++)
			rd(8'h80 + i, 8'hA0 + i, "pointer reg");
		rd(8'h90, 8'h00, "unmapped");
		wr(`OFS_POINTER_ONE_HIGH, 8'h03);
		wr(`OFS_POINTER_ONE_LOW, 8'h20);
		op(`OP_INDIRECT, 0, 0, 0, 3'b000, 16'h005A);
		chk("ptr one", {2'b00, 8'h03, 8'h20}, seen);
		chk("ind read", 8'h5A, accumulator);
		wr(`OFS_POINTER_TWO_HIGH, 8'h02);
		wr(`OFS_POINTER_TWO_LOW, 8'h25);
		op(`OP_INDIRECT, 0, 0, 0, 3'b011, 0);
		chk("ptr two", {2'b10, 8'h02, 8'h25}, seen);
		chk("rom addr", 12'h225, rom_addr);
		op(`OP_TABLE_LOOKUP, 0, 0, 0, 0, 16'hBEEF);
		chk("lookup low", 8'hEF, accumulator);
		rd(`OFS_LOOKUP_RESULT_HIGH, 8'hBE, "lookup high");
		foreach (ia[k]) begin
			ok = ia[k] >= `IMM_RAM_LOW && ia[k] <= `IMM_RAM_HIGH;
			op(`OP_IMM_TO_RAM, 0, 8'h3C, ia[k], 0, 0);
			chk("imm ram", {ok, !ok, 8'h00, ia[k], 8'h3C}, {seen, sw});
		end
		op(`OP_IMM_TO_ACC, 0, 8'h28, 0, 0, 0);
		chk("imm acc", 8'h28, accumulator);
		op(`OP_DIRECT_WRITE, 0, 0, 8'h12, 3'b100, 0);
		chk("bank0 write", {2'b10, 8'h00, 8'h12, 8'h28}, {seen, sw});
		op(`OP_DIRECT_WRITE, 0, 0, 8'h12, 3'b000, 0);
		chk("bank write", {2'b10, 8'h05, 8'h12}, seen);
		op(`OP_DIRECT_READ, 0, 0, 8'h12, 3'b000, 16'h0077);
		chk("direct read", 8'h77, accumulator);
		op(`OP_IMM_TO_ACC, 0, 8'h28, 0, 0, 0);
		op(`OP_JUMP, 12'h323, 0, 0, 0, 0);
		chk("jump", 12'h323, program_counter);
		op(`OP_PCL_MOVE, 0, 0, 0, 0, 0);
		chk("page move", 12'h328, program_counter);
		op(`OP_IMM_TO_ACC, 0, 8'hF0, 0, 0, 0);
		op(`OP_JUMP, 12'h3F0, 0, 0, 0, 0);
		op(`OP_PCL_ADD, 0, 0, 0, 0, 0);
		chk("carry high", 4'h4, program_counter[11:8]);
		op(`OP_JUMP, 12'h305, 0, 0, 0, 0);
		op(`OP_PCL_SUB, 0, 0, 0, 0, 0);
		chk("borrow high", 4'h3, program_counter[11:8]);
		op(`OP_JUMP, 12'h1A3, 0, 0, 0, 0);
		op(`OP_SKIP, 0, 0, 0, 0, 0);
		chk("skip", 12'h1A5, program_counter);
		op(`OP_CALL, 12'h200, 0, 0, 0, 0);
		chk("call", {12'h200, 3'h6}, {program_counter, return_index_bits});
		rd(8'hFE, 8'h01, "entry upper");
		rd(8'hFF, 8'hA6, "entry lower");
		op(`OP_CALL, 12'h300, 0, 0, 0, 0);
		op(`OP_IRQ_ENTRY, 12'h004, 0, 0, 0, 0);
		chk("irq entry", {12'h004, 3'h4}, {program_counter, return_index_bits});
		op(`OP_IRQ_RETURN, 0, 0, 0, 0, 0);
		chk("irq return", {12'h301, 3'h5}, {program_counter, return_index_bits});
		op(`OP_RETURN, 0, 0, 0, 0, 0);
		chk("return", 12'h201, program_counter);
		op(`OP_RETURN, 0, 0, 0, 0, 0);
		chk("last return", {12'h1A6, 3'h7}, {program_counter, return_index_bits});
		wr(8'hF0, 8'hFA);
		wr(8'hF1, 8'h5C);
		rd(8'hF0, 8'h0A, "sw entry upper");
		rd(8'hF1, 8'h5C, "sw entry lower");
		op(`OP_RETURN, 0, 0, 0, 0, 0);
		chk("wrap return", {12'hA5C, 3'h0}, {program_counter, return_index_bits});
		wr(`OFS_RETURN_STACK_INDEX, 8'h83);
		rd(`OFS_RETURN_STACK_INDEX, 8'h83, "index write");
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(`OFS_RETURN_STACK_INDEX, 8'h07, "index after reset");
		chk("pc after reset", 12'h000, program_counter);
		close_out;
	end
endmodule // test_pc_pointer_and_stack_unit
